// ===== tmh_pkg.sv
// Constants and types of the slot handshake message channel
package tmh_pkg;

  localparam logic [11:0] TMH_CTRL_OFS   = 12'h000;
  localparam logic [11:0] TMH_TXD_OFS    = 12'h004;
  localparam logic [11:0] TMH_RXD_OFS    = 12'h008;
  localparam logic [11:0] TMH_STAT_OFS   = 12'h00c;

  localparam int          TMH_TXF_BIT    = 0;
  localparam int          TMH_RXA_BIT    = 1;
  localparam int          TMH_HIE_BIT    = 2;
  localparam int          TMH_RIE_BIT    = 3;
  localparam int          TMH_EN_BIT     = 4;
  localparam int          TMH_PS_BIT     = 5;
  localparam int          TMH_CS_LSB     = 8;

  localparam int          TMH_RCVD_BIT   = 0;
  localparam int          TMH_EOR_BIT    = 1;
  localparam int          TMH_ACK_BIT    = 2;
  localparam int          TMH_ABT_BIT    = 3;
  localparam int          TMH_ACT_BIT    = 4;

  localparam logic        TMH_EN_RST     = 1'b1;
  localparam logic        TMH_PS_RST     = 1'b0;
  localparam logic [2:0]  TMH_CS_RST     = 3'h0;
  localparam logic        TMH_FLAG_IDLE  = 1'b1;

  localparam logic [7:0]  TMH_BASE_OFS   = 8'h10;
  localparam int          TMH_CS_SHIFT   = 5;
  localparam logic [7:0]  TMH_WIN_LEN    = 8'h10;
  localparam logic [7:0]  TMH_DATA_LEN   = 8'h08;
  localparam logic [7:0]  TMH_POS_ACK    = 8'h0e;
  localparam logic [7:0]  TMH_POS_VALID  = 8'h0f;

  typedef enum logic [1:0] {TMH_TX_IDLE, TMH_TX_SEND, TMH_TX_GAP, TMH_TX_ABORT} tmh_tx_state_type;
  typedef enum logic       {TMH_RX_IDLE, TMH_RX_MSG} tmh_rx_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic       ack;
    logic       valid;
  } tmh_frame_type;

  typedef struct packed {
    logic abt;
    logic ack;
    logic eor;
    logic rcvd;
  } tmh_stat_type;

endpackage : tmh_pkg

// ===== tmh_channel.sv
// Handshaked byte channel in one slot of a time-division frame, APB registers
// How it works
// - Loaded byte with transmit flag set drives valid flag active (0).
// - Received valid byte is stored; byte-received status set when enabled.
// - Setting receive-ack control acks first byte; transmitter raises byte-acked.
// - Each further byte: valid flag inactive exactly one frame, then active.
// - After reading received byte, ack flag inactive one frame, then active.
// - Clearing transmit flag forces valid flag inactive (1) in later frames.
// - Valid flag inactive two consecutive frames raises end-of-receive status.
// - Clearing receive-ack control forces ack inactive; transmit-active returns 0.
// - Transmitter may repeat the same byte; valid flag then stays active.
// - Receiver needs identical bytes in two successive frames; else waits.
// - Transmitter checks driven data and valid bits; mismatch aborts transmission.
// - Current byte is resent every frame until acked, ended or aborted.
// - Ack flag inactive two frames during transfer raises abort status.
// - Transmitter abort ends reception and is reported as end-of-receive.
// - With receive interrupt enable 0, byte-received status never sets.
// - Enable 1, ack control 0: byte-received only for first byte.
// - Enable and ack control both 1: every marked byte stored and reported.
// - One handshake enable gates end-of-receive, byte-acked and abort status.
// - Register commands run strictly one at a time.
// - Flags active low; pending byte placed once per frame until acked.
// - After reset channel enabled on first slot, output on downstream line.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tmh_channel
  import tmh_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_sync,
  input  wire logic        bit_clock,
  input  wire logic        upstream_line_in,
  output logic             upstream_line_out,
  output logic             upstream_line_oe,
  input  wire logic        downstream_line_in,
  output logic             downstream_line_out,
  output logic             downstream_line_oe,
  output logic             irq_req
);

  function automatic logic [7:0] slot_base(input logic [2:0] cs);
    slot_base = TMH_BASE_OFS + {cs, 5'h00};
  endfunction : slot_base

  // Control and data registers
  logic             tx_flag_ctrl_r;
  logic             rx_ack_ctrl_r;
  logic             handshake_irq_enable_r;
  logic             rx_irq_enable_r;
  logic             channel_enable_r;
  logic             port_select_r;
  logic [2:0]       channel_select_r;
  logic [7:0]       tx_byte_reg_r;
  logic [7:0]       rx_byte_reg_r;
  tmh_stat_type     stat_r;
  tmh_stat_type     stat_set;
  tmh_stat_type     stat_nxt;
  logic [31:0]      prdata_r;
  logic             irq_r;

  // Link side state
  logic [2:0]       fs_s;
  logic [2:0]       bc_s;
  logic [1:0]       up_s;
  logic [1:0]       dn_s;
  logic [7:0]       bit_cnt_r;
  tmh_frame_type    cur_r;
  tmh_frame_type    prev_r;
  logic             col_r;
  logic             line_oe_r;
  tmh_tx_state_type tx_st_r;
  logic             tx_valid_flag_r;
  logic             tx_active_r;
  logic             tx_wait_r;
  logic             tx_acked_once_r;
  logic             tx_new_r;
  logic [7:0]       tx_out_r;
  tmh_rx_state_type rx_st_r;
  logic             rx_ack_flag_r;
  logic             rx_new_r;
  logic             rx_unacked_r;
  logic             rx_read_r;

  // Bus decode
  wire        acc      = psel & penable;
  wire        wr       = acc & pwrite;
  wire        sel_ctrl = (paddr == TMH_CTRL_OFS);
  wire        sel_txd  = (paddr == TMH_TXD_OFS);
  wire        sel_rxd  = (paddr == TMH_RXD_OFS);
  wire        sel_stat = (paddr == TMH_STAT_OFS);
  wire        hit      = sel_ctrl | sel_txd | sel_rxd | sel_stat;
  wire        wr_ctrl  = wr & sel_ctrl;
  wire        wr_txd   = wr & sel_txd;
  wire        wr_stat  = wr & sel_stat;
  wire        rd_rxd   = acc & ~pwrite & sel_rxd;
  wire [31:0] ctrl_rd  = {21'h000000, channel_select_r, 2'h0, port_select_r, channel_enable_r,
                          rx_irq_enable_r, handshake_irq_enable_r, rx_ack_ctrl_r, tx_flag_ctrl_r};
  wire [31:0] stat_rd  = {27'h0000000, tx_active_r, stat_r};
  wire [31:0] rd_mux   = sel_ctrl ? ctrl_rd :
                         sel_txd  ? {24'h000000, tx_byte_reg_r} :
                         sel_rxd  ? {24'h000000, rx_byte_reg_r} :
                         sel_stat ? stat_rd : 32'h00000000;

  assign pready  = 1'b1;                  // Zero-wait; each access completes before the next
  assign pslverr = acc & ~hit;
  assign prdata  = prdata_r;
  assign irq_req = irq_r;

  // Frame and bit position tracking
  wire        fs_rise  = fs_s[1] & ~fs_s[2];
  wire        bc_fall  = ~bc_s[1] & bc_s[2];
  wire        in_line  = port_select_r ? dn_s[1] : up_s[1];
  wire        own_line = port_select_r ? up_s[1] : dn_s[1];
  wire [7:0]  win      = bit_cnt_r - slot_base(channel_select_r);
  wire        in_win   = (win < TMH_WIN_LEN) & channel_enable_r;
  wire        pos_data = win < TMH_DATA_LEN;
  wire        sample   = bc_fall & in_win;
  wire        tick     = sample & (win == TMH_POS_VALID);
  wire        tx_busy  = (tx_st_r == TMH_TX_SEND) | (tx_st_r == TMH_TX_GAP);
  wire        drv_bit  = pos_data ? (tx_busy ? tx_out_r[~win[2:0]] : TMH_FLAG_IDLE) :
                         (win == TMH_POS_ACK)   ? rx_ack_flag_r :
                         (win == TMH_POS_VALID) ? tx_valid_flag_r : TMH_FLAG_IDLE;
  wire        chk_bit  = tx_busy & (pos_data | (win == TMH_POS_VALID));
  wire        mismatch = sample & chk_bit & (own_line != drv_bit);
  wire        col_now  = col_r | mismatch;

  tmh_frame_type fr;
  assign fr = '{data: cur_r.data, ack: cur_r.ack, valid: in_line};

  wire        ack_idle2  = fr.ack & prev_r.ack;
  wire        val_idle2  = fr.valid & prev_r.valid;
  wire        ack_edge   = ~fr.ack & prev_r.ack;
  wire        confirm    = rx_new_r & ~fr.valid & ~prev_r.valid & (fr.data == prev_r.data);
  wire        rx_store   = tick & confirm & ((rx_st_r == TMH_RX_IDLE) | rx_ack_ctrl_r);

  assign upstream_line_out   = 1'b0;
  assign downstream_line_out = 1'b0;
  assign upstream_line_oe    = port_select_r & line_oe_r;
  assign downstream_line_oe  = ~port_select_r & line_oe_r;

  // Status: set wins over write-one-to-clear
  always_comb
  begin
    stat_set      = '0;
    stat_set.rcvd = rx_store & rx_irq_enable_r;
    stat_set.eor  = tick & (rx_st_r == TMH_RX_MSG) & val_idle2 & handshake_irq_enable_r;
    stat_set.ack  = tick & (tx_st_r == TMH_TX_SEND) & ~col_now & tx_flag_ctrl_r & tx_wait_r
                    & ack_edge & handshake_irq_enable_r;
    stat_set.abt  = tick & tx_busy & tx_flag_ctrl_r & handshake_irq_enable_r
                    & (col_now | ((tx_st_r == TMH_TX_SEND) & tx_acked_once_r & ack_idle2));
    stat_nxt      = (stat_r & ~(wr_stat ? tmh_stat_type'(pwdata[3:0]) : '0)) | stat_set;
  end

  // Register file
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_flag_ctrl_r         <= 1'b0;
      rx_ack_ctrl_r          <= 1'b0;
      handshake_irq_enable_r <= 1'b0;
      rx_irq_enable_r        <= 1'b0;
      channel_enable_r       <= TMH_EN_RST;
      port_select_r          <= TMH_PS_RST;
      channel_select_r       <= TMH_CS_RST;
      tx_byte_reg_r          <= 8'h00;
      stat_r                 <= '0;
      prdata_r               <= 32'h00000000;
      irq_r                  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        tx_flag_ctrl_r         <= pwdata[TMH_TXF_BIT];
        rx_ack_ctrl_r          <= pwdata[TMH_RXA_BIT];
        handshake_irq_enable_r <= pwdata[TMH_HIE_BIT];
        rx_irq_enable_r        <= pwdata[TMH_RIE_BIT];
        channel_enable_r       <= pwdata[TMH_EN_BIT];
        port_select_r          <= pwdata[TMH_PS_BIT];
        channel_select_r       <= pwdata[TMH_CS_LSB+2:TMH_CS_LSB];
      end
      if (wr_txd)
        tx_byte_reg_r <= pwdata[7:0];
      if (psel & ~penable)
        prdata_r <= rd_mux;
      stat_r <= stat_nxt;
      irq_r  <= |stat_nxt;
    end
  end

  // Synchronisers and bit counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fs_s      <= 3'h0;
      bc_s      <= 3'h0;
      up_s      <= 2'h3;
      dn_s      <= 2'h3;
      bit_cnt_r <= 8'h00;
      line_oe_r <= 1'b0;
    end
    else
    begin
      fs_s <= {fs_s[1:0], frame_sync};
      bc_s <= {bc_s[1:0], bit_clock};
      up_s <= {up_s[0], upstream_line_in};
      dn_s <= {dn_s[0], downstream_line_in};
      if (fs_rise)
        bit_cnt_r <= 8'h00;
      else if (bc_fall)
        bit_cnt_r <= bit_cnt_r + 8'h01;
      line_oe_r <= in_win & ~drv_bit;
    end
  end

  // Per-frame sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_r  <= '{data: 8'h00, ack: TMH_FLAG_IDLE, valid: TMH_FLAG_IDLE};
      prev_r <= '{data: 8'h00, ack: TMH_FLAG_IDLE, valid: TMH_FLAG_IDLE};
      col_r  <= 1'b0;
    end
    else if (tick)
    begin
      prev_r <= fr;
      col_r  <= 1'b0;
    end
    else if (sample)
    begin
      if (pos_data)
        cur_r.data <= {cur_r.data[6:0], in_line};
      if (win == TMH_POS_ACK)
        cur_r.ack <= in_line;
      col_r <= col_now;
    end
  end

  // Transmitter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_r         <= TMH_TX_IDLE;
      tx_valid_flag_r <= TMH_FLAG_IDLE;
      tx_active_r     <= 1'b0;
      tx_wait_r       <= 1'b0;
      tx_acked_once_r <= 1'b0;
      tx_new_r        <= 1'b0;
      tx_out_r        <= 8'h00;
    end
    else
    begin
      if (wr_txd)
        tx_new_r <= 1'b1;
      if (tick)
      begin
        case (tx_st_r)
          TMH_TX_IDLE:
          begin
            tx_valid_flag_r <= TMH_FLAG_IDLE;
            if (tx_flag_ctrl_r & ~tx_active_r)
            begin
              tx_st_r         <= TMH_TX_SEND;
              tx_out_r        <= tx_byte_reg_r;
              tx_valid_flag_r <= 1'b0;
              tx_active_r     <= 1'b1;
              tx_wait_r       <= 1'b1;
              tx_acked_once_r <= 1'b0;
              tx_new_r        <= wr_txd;
            end
            else if (ack_idle2)
              tx_active_r <= 1'b0;
          end
          TMH_TX_SEND:
          begin
            if (!tx_flag_ctrl_r)
            begin
              tx_st_r         <= TMH_TX_IDLE;
              tx_valid_flag_r <= TMH_FLAG_IDLE;
            end
            else if (col_now | (tx_acked_once_r & ack_idle2))
            begin
              tx_st_r         <= TMH_TX_ABORT;
              tx_valid_flag_r <= TMH_FLAG_IDLE;
            end
            else if (tx_wait_r & ack_edge)
            begin
              tx_wait_r       <= 1'b0;
              tx_acked_once_r <= 1'b1;
            end
            else if (~tx_wait_r & tx_new_r)
            begin
              tx_st_r         <= TMH_TX_GAP;
              tx_valid_flag_r <= TMH_FLAG_IDLE;
            end
            // Otherwise the same byte goes out again, flag stays active
          end
          TMH_TX_GAP:
          begin
            if (!tx_flag_ctrl_r)
              tx_st_r <= TMH_TX_IDLE;
            else if (col_now)
              tx_st_r <= TMH_TX_ABORT;
            else
            begin
              tx_st_r         <= TMH_TX_SEND;
              tx_out_r        <= tx_byte_reg_r;
              tx_valid_flag_r <= 1'b0;
              tx_wait_r       <= 1'b1;
              tx_new_r        <= wr_txd;
            end
          end
          TMH_TX_ABORT:
          begin
            tx_valid_flag_r <= TMH_FLAG_IDLE;
            if (!tx_flag_ctrl_r)
              tx_st_r <= TMH_TX_IDLE;
          end
          default:
            tx_st_r <= TMH_TX_IDLE;
        endcase
      end
    end
  end

  // Receiver
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_r       <= TMH_RX_IDLE;
      rx_ack_flag_r <= TMH_FLAG_IDLE;
      rx_new_r      <= 1'b0;
      rx_unacked_r  <= 1'b0;
      rx_read_r     <= 1'b0;
      rx_byte_reg_r <= 8'h00;
    end
    else
    begin
      if (rd_rxd)
        rx_read_r <= 1'b1;
      if (tick)
      begin
        if (~fr.valid & prev_r.valid)
          rx_new_r <= 1'b1;
        else if (confirm)
          rx_new_r <= 1'b0;
        if (~rx_ack_ctrl_r | (rx_st_r == TMH_RX_IDLE))
          rx_ack_flag_r <= TMH_FLAG_IDLE;
        else if (rx_ack_flag_r & rx_unacked_r)
        begin
          rx_ack_flag_r <= 1'b0;
          rx_unacked_r  <= 1'b0;
        end
        else if (~rx_ack_flag_r & rx_unacked_r & rx_read_r & ~rd_rxd)
        begin
          rx_ack_flag_r <= TMH_FLAG_IDLE;
          rx_read_r     <= 1'b0;
        end
        case (rx_st_r)
          TMH_RX_IDLE:
          begin
            if (rx_store)
              rx_st_r <= TMH_RX_MSG;
          end
          TMH_RX_MSG:
          begin
            if (val_idle2)
            begin
              rx_st_r      <= TMH_RX_IDLE;
              rx_unacked_r <= 1'b0;
            end
          end
          default:
            rx_st_r <= TMH_RX_IDLE;
        endcase
        if (rx_store & ~(val_idle2 & (rx_st_r == TMH_RX_MSG)))
        begin
          rx_byte_reg_r <= fr.data;
          rx_unacked_r  <= 1'b1;
          rx_read_r     <= rd_rxd;
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_START_ACTIVE: assert property ((tick && tx_st_r == TMH_TX_IDLE && tx_flag_ctrl_r && !tx_active_r)
    |=> (!tx_valid_flag_r && tx_active_r && tx_st_r == TMH_TX_SEND)) else $error("start not taken");
  AST_IDLE_FLAG: assert property ((tick && !tx_flag_ctrl_r && tx_st_r != TMH_TX_GAP)
    |=> tx_valid_flag_r) else $error("valid flag not forced idle");
  AST_GAP_ONE: assert property ((tick && tx_st_r == TMH_TX_GAP && tx_flag_ctrl_r && !col_now)
    |=> (!tx_valid_flag_r && tx_st_r == TMH_TX_SEND)) else $error("gap longer than one frame");
  AST_EOR_SET: assert property ((tick && rx_st_r == TMH_RX_MSG && val_idle2 && handshake_irq_enable_r)
    |=> (stat_r.eor && rx_st_r == TMH_RX_IDLE)) else $error("end of receive missed");
  AST_NO_RCVD: assert property ((!rx_irq_enable_r && !stat_r.rcvd) |=> !stat_r.rcvd)
    else $error("received status without enable");
  AST_COLLIDE: assert property ((tick && tx_st_r == TMH_TX_SEND && tx_flag_ctrl_r && col_now)
    |=> (tx_st_r == TMH_TX_ABORT && tx_valid_flag_r)) else $error("collision not aborted");
  AST_FIRST_ACK: assert property ((tick && rx_ack_ctrl_r && rx_st_r == TMH_RX_MSG && rx_ack_flag_r && rx_unacked_r)
    |=> !rx_ack_flag_r) else $error("ack not driven");
  AST_IRQ_FOLLOW: assert property ($rose(stat_r.abt) |-> irq_req) else $error("request not raised");
  AST_ONE_TICK: assert property (tick |=> !tick [*2]) else $error("frame sampled twice");

endmodule : tmh_channel
`default_nettype wire

// ===== tmh_peer.sv
// Bus peer: frame timing, byte transmitter and acknowledging receiver
`timescale 1ns/100ps
`default_nettype none
module tmh_peer (
  input  wire logic       tx_on,
  input  wire logic [7:0] tx_byte,
  input  wire logic       abort,
  input  wire logic       clash,
  input  wire logic       down_line,
  output logic            frame_sync,
  output logic            bit_clock,
  output logic            up_drive,
  output logic            down_drive,
  output logic [7:0]      rx_last,
  output logic            ack_seen,
  output logic            valid_seen,
  output var int          ack_falls,
  output var int          valid_falls
);
  int         bitn = 31;
  logic [7:0] tx_d = 8'h00;
  logic [7:0] sd = 8'h00;
  logic [7:0] pd = 8'h00;
  logic       tx_v = 1'b1;
  logic       ack_n = 1'b1;
  logic       pend = 1'b0;
  logic       taken = 1'b0;
  logic       sa = 1'b1;
  logic       sv = 1'b1;
  initial
  begin
    frame_sync = 1'b0;
    bit_clock = 1'b0;
    up_drive = 1'b1;
    down_drive = 1'b1;
    rx_last = 8'h00;
    ack_seen = 1'b1;
    valid_seen = 1'b1;
    ack_falls = 0;
    valid_falls = 0;
  end
  always #100 bit_clock = ~bit_clock;
  // Drive after rise; decide once per frame on last frame's samples
  always @(posedge bit_clock)
  begin
    bitn = (bitn == 31) ? 0 : bitn + 1;
    if (bitn == 0)
    begin
      if (sa === 1'b0 && ack_seen === 1'b1)
        ack_falls++;
      if (sv === 1'b0 && valid_seen === 1'b1)
        valid_falls++;
      if (pend)
        ack_n = 1'b0;
      pend = 1'b0;
      if (sv)
      begin
        taken = 1'b0;
        if (valid_seen)
          ack_n = 1'b1;
      end
      else if (!valid_seen && sd == pd && !taken)
      begin
        taken = 1'b1;
        rx_last = sd;
        pend = !ack_n;
        ack_n = !ack_n;
      end
      if (abort)
        ack_n = 1'b1;
      ack_seen = sa;
      valid_seen = sv;
      pd = sd;
      if (!tx_on)
        tx_v = 1'b1;
      else if (tx_v)
      begin
        tx_v = 1'b0;
        tx_d = tx_byte;
      end
      else if (tx_d != tx_byte)
        tx_v = 1'b1;
    end
    frame_sync = (bitn == 0);
    down_drive = !(clash && bitn == 16);
    up_drive = 1'b1;
    if (bitn >= 16 && bitn < 24)
      up_drive = tx_d[23 - bitn];
    if (bitn == 30)
      up_drive = ack_n;
    if (bitn == 31)
      up_drive = tx_v;
  end
  // Sample before the device moves its output
  always @(negedge bit_clock)
  begin
    if (bitn >= 16 && bitn < 24)
      sd = {sd[6:0], down_line};
    if (bitn == 30)
      sa = down_line;
    if (bitn == 31)
      sv = down_line;
  end
endmodule : tmh_peer
`default_nettype wire

// ===== tmh_channel_bench.sv
// Bench: register access and message transfers against the bus peer
`timescale 1ns/100ps
`default_nettype none
module tmh_channel_bench
  import tmh_pkg::*;
;
  localparam logic [31:0] TXF = 32'h1 << TMH_TXF_BIT;
  localparam logic [31:0] RXA = 32'h1 << TMH_RXA_BIT;
  localparam logic [31:0] HIE = 32'h1 << TMH_HIE_BIT;
  localparam logic [31:0] RIE = 32'h1 << TMH_RIE_BIT;
  localparam logic [31:0] EN = 32'h1 << TMH_EN_BIT;
  localparam logic [31:0] RCV = 32'h1 << TMH_RCVD_BIT;
  localparam logic [31:0] EOR = 32'h1 << TMH_EOR_BIT;
  localparam logic [31:0] ACK = 32'h1 << TMH_ACK_BIT;
  localparam logic [31:0] ABT = 32'h1 << TMH_ABT_BIT;
  localparam logic [31:0] ACT = 32'h1 << TMH_ACT_BIT;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        frame_sync, bit_clock, up_oe, dn_oe, irq_req, peer_up, peer_dn;
  logic        tx_on, p_abort, clash, ack_seen, valid_seen;
  logic [7:0]  tx_byte, rx_last;
  int          ack_falls, valid_falls, failures, checks_done;
  wire logic   up_wire = ~up_oe & peer_up;
  wire logic   dn_wire = ~dn_oe & peer_dn;
  tmh_channel tmh_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync(frame_sync), .bit_clock(bit_clock), .upstream_line_in(up_wire), .upstream_line_out(),
    .upstream_line_oe(up_oe), .downstream_line_in(dn_wire), .downstream_line_out(),
    .downstream_line_oe(dn_oe), .irq_req(irq_req));
  tmh_peer tmh_peer_inst (.tx_on(tx_on), .tx_byte(tx_byte), .abort(p_abort), .clash(clash),
    .down_line(dn_wire), .frame_sync(frame_sync), .bit_clock(bit_clock), .up_drive(peer_up),
    .down_drive(peer_dn), .rx_last(rx_last), .ack_seen(ack_seen), .valid_seen(valid_seen),
    .ack_falls(ack_falls), .valid_falls(valid_falls));
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  task automatic close_out;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      failures++;
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rv & m, e);
  endtask : rdm
  task automatic fr(input int n);
    repeat (n) @(posedge frame_sync);
    @(posedge pclk);
  endtask : fr
  initial
  begin
    #1_500_000;
    failures++;
    close_out();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_on, p_abort, clash, tx_byte, failures, checks_done} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdm(TMH_CTRL_OFS, '1, EN);
    rdm(TMH_STAT_OFS, ACT, 0);
    rdm(12'h010, '1, 0);
    chk(32'(err), 1);
    apb(TMH_TXD_OFS, 1'b1, 32'ha5);
    apb(TMH_CTRL_OFS, 1'b1, EN | HIE | TXF);
    fr(5);
    rdm(TMH_STAT_OFS, 32'h1f, ACK | ACT);
    chk(32'(rx_last), 32'ha5);
    chk(32'(irq_req), 1);
    apb(TMH_STAT_OFS, 1'b1, 32'hf);
    chk(32'(irq_req), 0);
    apb(TMH_TXD_OFS, 1'b1, 32'h3c);
    fr(7);
    rdm(TMH_STAT_OFS, ACK, ACK);
    chk(32'(rx_last), 32'h3c);
    chk(valid_falls, 2);
    apb(TMH_CTRL_OFS, 1'b1, EN | HIE);
    fr(6);
    chk(32'(valid_seen), 1);
    rdm(TMH_STAT_OFS, ACT, 0);
    apb(TMH_STAT_OFS, 1'b1, 32'hf);
    apb(TMH_TXD_OFS, 1'b1, 32'h11);
    apb(TMH_CTRL_OFS, 1'b1, EN | HIE | TXF);
    fr(5);
    p_abort <= 1'b1;
    fr(4);
    rdm(TMH_STAT_OFS, ABT, ABT);
    p_abort <= 1'b0;
    apb(TMH_CTRL_OFS, 1'b1, EN | HIE);
    fr(4);
    apb(TMH_STAT_OFS, 1'b1, 32'hf);
    clash <= 1'b1;
    apb(TMH_TXD_OFS, 1'b1, 32'h80);
    apb(TMH_CTRL_OFS, 1'b1, EN | HIE | TXF);
    fr(4);
    rdm(TMH_STAT_OFS, ABT, ABT);
    clash <= 1'b0;
    apb(TMH_CTRL_OFS, 1'b1, EN | HIE | RIE);
    fr(4);
    apb(TMH_STAT_OFS, 1'b1, 32'hf);
    tx_byte <= 8'h5a;
    tx_on <= 1'b1;
    fr(5);
    rdm(TMH_STAT_OFS, RCV, RCV);
    rdm(TMH_RXD_OFS, 32'hff, 32'h5a);
    chk(ack_falls, 0);
    apb(TMH_CTRL_OFS, 1'b1, EN | HIE | RIE | RXA);
    fr(3);
    chk(ack_falls, 1);
    apb(TMH_STAT_OFS, 1'b1, 32'hf);
    tx_byte <= 8'hc3;
    fr(5);
    rdm(TMH_STAT_OFS, RCV, RCV);
    rdm(TMH_RXD_OFS, 32'hff, 32'hc3);
    fr(4);
    chk(ack_falls, 2);
    tx_on <= 1'b0;
    fr(4);
    rdm(TMH_STAT_OFS, EOR, EOR);
    apb(TMH_CTRL_OFS, 1'b1, EN);
    fr(3);
    chk(32'(ack_seen), 1);
    apb(TMH_STAT_OFS, 1'b1, 32'hf);
    tx_byte <= 8'h77;
    tx_on <= 1'b1;
    fr(5);
    tx_on <= 1'b0;
    fr(4);
    rdm(TMH_STAT_OFS, 32'hf, 0);
    rdm(TMH_RXD_OFS, 32'hff, 32'h77);
    close_out();
  end
endmodule : tmh_channel_bench
`default_nettype wire
